/* logic/pts_params.svh */
/*
 * Constants of the housekeeping block: sizes, timing and reset values.
 * Assumes a single core clock of 40 MHz.
 */
`ifndef PTS_PARAMS_SVH
`define PTS_PARAMS_SVH
`define PTS_SIG_W        64
`define PTS_NUM_OUT      10
`define PTS_CLK_PS       25000
`define PTS_TPR_NS       1000
`define PTS_TPR_CYC      ((`PTS_TPR_NS * 1000) / `PTS_CLK_PS)
`define PTS_CNT_W        6
`define PTS_SIG_RST      64'h0000_0000_0000_0000
`endif

/* logic/pts_pkg.sv */
/*
 * Types of the housekeeping block.
 * Assumes pts_params.svh is compiled alongside.
 */
package pts_pkg;
   typedef enum logic [1:0] {
      PTS_IDLE,
      PTS_ERASE,
      PTS_WRITE
   } pts_prog_type;
endpackage

/* logic/pts_housekeeping.sv */
/*
 * Housekeeping of a small programmable logic device: signature, readback
 * lock, programming cycle, register preload, power-up reset, pin pull-ups.
 * Assumes a programmer drives the program, read and preload ports
 * synchronously to core_clk.
 */
`timescale 1ns/1ps
`include "pts_params.svh"
module pts_housekeeping #(
   parameter int NUM_OUT = `PTS_NUM_OUT,
   parameter int SIG_W   = `PTS_SIG_W
) (
   input  wire logic               core_clk,
   input  wire logic               rst_n,
   input  wire logic               progLoad,
   input  wire logic [SIG_W-1:0]   progSignature,
   input  wire logic [NUM_OUT-1:0] progPolarity,
   input  wire logic [NUM_OUT-1:0] progEnable,
   input  wire logic               progLock,
   input  wire logic               cfgReadReq,
   input  wire logic               sigReadReq,
   input  wire logic               testMode,
   input  wire logic               preloadStrobe,
   input  wire logic [NUM_OUT-1:0] preloadState,
   input  wire logic [NUM_OUT-1:0] pinIn,
   input  wire logic [NUM_OUT-1:0] pinFloat,
   output logic                    progBusy,
   output logic                    cfgReadValid,
   output logic                    cfgReadRefused,
   output logic [NUM_OUT-1:0]      cfgReadPolarity,
   output logic [NUM_OUT-1:0]      cfgReadEnable,
   output logic                    sigReadValid,
   output logic [SIG_W-1:0]        sigReadData,
   output logic                    powerupDone,
   output logic [NUM_OUT-1:0]      pinOut,
   output logic [NUM_OUT-1:0]      pinOe_n,
   output logic [NUM_OUT-1:0]      pinSense
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rstPipe;
   logic       rstSync_n;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstPipe <= 2'h0;
      end else begin
         rstPipe <= {rstPipe[0], 1'b1};
      end
   end
   assign rstSync_n = rstPipe[1];

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      pts_pkg::pts_prog_type  progState;
      logic [SIG_W-1:0]       signature;
      logic [NUM_OUT-1:0]     polarity;
      logic [NUM_OUT-1:0]     enable;
      logic                   lock;
      logic [SIG_W-1:0]       pendSig;
      logic [NUM_OUT-1:0]     pendPol;
      logic [NUM_OUT-1:0]     pendEn;
      logic                   pendLock;
      logic [NUM_OUT-1:0]     q;
      logic [`PTS_CNT_W-1:0]  porCount;
      logic                   porDone;
      logic                   progBusy;
      logic                   cfgReadValid;
      logic                   cfgReadRefused;
      logic [NUM_OUT-1:0]     cfgReadPolarity;
      logic [NUM_OUT-1:0]     cfgReadEnable;
      logic                   sigReadValid;
      logic [SIG_W-1:0]       sigReadData;
      logic [NUM_OUT-1:0]     pinOut;
      logic [NUM_OUT-1:0]     pinOe_n;
      logic [NUM_OUT-1:0]     pinSense;
   } pts_state_type;

   localparam logic [`PTS_CNT_W-1:0] TPR_CYC = `PTS_CNT_W'(`PTS_TPR_CYC);

   pts_state_type st;
   pts_state_type next_st;
   logic [NUM_OUT-1:0] sensed;
   logic [NUM_OUT-1:0] next_q;

   // ----------------------------------------------------------------
   // Pin sensing
   // ----------------------------------------------------------------
   // An undriven pin is pulled up, so it reads as one.
   genvar gi;
   generate
      for (gi = 0; gi < NUM_OUT; gi++) begin : g_sense
         assign sensed[gi] = pinFloat[gi] | pinIn[gi];
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.cfgReadValid   = 1'b0;
      next_st.cfgReadRefused = 1'b0;
      next_st.sigReadValid   = 1'b0;
      next_st.pinSense       = sensed;
      // Registers stay cleared until the power-up reset time has run out.
      if (!st.porDone) begin
         next_q = '0;
         if (st.porCount == TPR_CYC - `PTS_CNT_W'(1)) begin
            next_st.porDone = 1'b1;
         end else begin
            next_st.porCount = st.porCount + `PTS_CNT_W'(1);
         end
      end else if (testMode) begin
         // Feedback is broken: the register holds unless preload strikes.
         next_q = preloadStrobe ? preloadState : st.q;
      end else begin
         next_q = sensed;
      end
      next_st.q = next_q;
      unique case (st.progState)
         pts_pkg::PTS_IDLE: begin
            if (progLoad) begin
               next_st.pendSig   = progSignature;
               next_st.pendPol   = progPolarity;
               next_st.pendEn    = progEnable;
               next_st.pendLock  = progLock;
               next_st.progBusy  = 1'b1;
               next_st.progState = pts_pkg::PTS_ERASE;
            end
         end
         pts_pkg::PTS_ERASE: begin
            // Erase is part of every cycle; apart from reset, it alone can clear the lock.
            next_st.polarity  = '0;
            next_st.enable    = '0;
            next_st.signature = `PTS_SIG_RST;
            next_st.lock      = 1'b0;
            next_st.progState = pts_pkg::PTS_WRITE;
         end
         pts_pkg::PTS_WRITE: begin
            next_st.signature = st.pendSig;
            next_st.polarity  = st.pendPol;
            next_st.enable    = st.pendEn;
            next_st.lock      = st.pendLock;
            next_st.progBusy  = 1'b0;
            next_st.progState = pts_pkg::PTS_IDLE;
         end
         default: begin
            next_st.progState = pts_pkg::PTS_IDLE;
         end
      endcase
      if (cfgReadReq) begin
         next_st.cfgReadValid    = 1'b1;
         next_st.cfgReadRefused  = st.lock;
         next_st.cfgReadPolarity = st.lock ? '0 : st.polarity;
         next_st.cfgReadEnable   = st.lock ? '0 : st.enable;
      end
      if (sigReadReq) begin
         next_st.sigReadValid = 1'b1;
         next_st.sigReadData  = st.signature;
      end
      // A zero register shows as low on a true pin, high on an inverted one.
      next_st.pinOut  = next_q ^ ~next_st.polarity;
      next_st.pinOe_n = ~next_st.enable;
   end

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         st <= '0;
         st.progState <= pts_pkg::PTS_IDLE;
         st.signature <= `PTS_SIG_RST;
         st.pinOut    <= '1;
         st.pinOe_n   <= '1;
         st.pinSense  <= '1;
      end else begin
         st <= next_st;
      end
   end

   assign progBusy        = st.progBusy;
   assign cfgReadValid    = st.cfgReadValid;
   assign cfgReadRefused  = st.cfgReadRefused;
   assign cfgReadPolarity = st.cfgReadPolarity;
   assign cfgReadEnable   = st.cfgReadEnable;
   assign sigReadValid    = st.sigReadValid;
   assign sigReadData     = st.sigReadData;
   assign powerupDone     = st.porDone;
   assign pinOut          = st.pinOut;
   assign pinOe_n         = st.pinOe_n;
   assign pinSense        = st.pinSense;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sig_always_read_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
      sigReadReq |=> sigReadValid && sigReadData == $past(st.signature))
      else $error("signature read not answered");
   lock_refuse_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
      (cfgReadReq && st.lock) |=> cfgReadRefused && cfgReadPolarity == '0)
      else $error("locked configuration was read");
   lock_clear_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
      $fell(st.lock) |-> $past(st.progState) == pts_pkg::PTS_ERASE)
      else $error("lock cleared outside programming");
   auto_erase_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
      (st.progState == pts_pkg::PTS_IDLE && progLoad) |=> ##1 st.lock == 1'b0
      ##1 st.lock == $past(progLock, 3))
      else $error("programming cycle did not erase");
   preload_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
      (st.porDone && testMode && preloadStrobe) |=> st.q == $past(preloadState))
      else $error("preload not captured");
   preload_hold_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
      (st.porDone && testMode && !preloadStrobe) |=> $stable(st.q))
      else $error("register moved in test mode");
   por_clear_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
      !st.porDone |-> st.q == '0 && st.porCount < TPR_CYC)
      else $error("register not cleared at power-up");
   pin_polarity_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
      pinOut == (st.q ^ ~st.polarity) && pinOe_n == ~st.enable)
      else $error("pin does not follow polarity");
   pullup_a: assert property (@(posedge core_clk) disable iff (!rstSync_n)
      pinFloat != '0 |=> (pinSense & $past(pinFloat)) == $past(pinFloat))
      else $error("floating pin not read as one");
endmodule

/* testbench/pts_pin_board.sv */
/*
 * Board model of the ten device pins: resolves each wire from the device
 * enable and an outside driver. Assumes the bench picks the driven pins.
 */
`timescale 1ns/1ps
module pts_pin_board (
   input  wire logic       core_clk,
   input  wire logic [9:0] pinOut,
   input  wire logic [9:0] pinOe_n,
   input  wire logic [9:0] extDrive,
   input  wire logic [9:0] extVal,
   output logic      [9:0] pinIn,
   output logic      [9:0] pinFloat
);
   // ---------------------------------------------------------------
   // Wire resolution
   // ---------------------------------------------------------------
   logic [9:0] noise;
   // A floating wire toggles so that a stale level can never pass.
   always_ff @(posedge core_clk) begin
      noise <= (noise === 10'h155) ? 10'h2AA : 10'h155;
   end
   assign pinFloat = pinOe_n & ~extDrive;
   assign pinIn = (~pinOe_n & pinOut) | (pinOe_n & extDrive & extVal) | (pinFloat & noise);
endmodule

/* testbench/pts_housekeeping_test.sv */
/*
 * Self-checking bench of the housekeeping block with a pin board model.
 * Assumes the design header pts_params.svh is on the include path.
 */
`timescale 1ns/1ps
`include "pts_params.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; \
   $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module pts_housekeeping_test;
   logic core_clk, rst_n, progLoad, progLock, cfgReadReq, sigReadReq, testMode, preloadStrobe;
   logic [63:0] progSignature, sigReadData, sig;
   logic [9:0]  progPolarity, progEnable, preloadState, pinIn, pinFloat, extDrive, extVal;
   logic [9:0]  cfgReadPolarity, cfgReadEnable, pinOut, pinOe_n, pinSense, pol, en, st;
   logic        progBusy, cfgReadValid, cfgReadRefused, sigReadValid, powerupDone, erased;
   int          err_total = 0, n_compared = 0, seed = 32'hFFA88B40, cnt;
   pts_housekeeping dut (
      .core_clk        (core_clk),
      .rst_n           (rst_n),
      .progLoad        (progLoad),
      .progSignature   (progSignature),
      .progPolarity    (progPolarity),
      .progEnable      (progEnable),
      .progLock        (progLock),
      .cfgReadReq      (cfgReadReq),
      .sigReadReq      (sigReadReq),
      .testMode        (testMode),
      .preloadStrobe   (preloadStrobe),
      .preloadState    (preloadState),
      .pinIn           (pinIn),
      .pinFloat        (pinFloat),
      .progBusy        (progBusy),
      .cfgReadValid    (cfgReadValid),
      .cfgReadRefused  (cfgReadRefused),
      .cfgReadPolarity (cfgReadPolarity),
      .cfgReadEnable   (cfgReadEnable),
      .sigReadValid    (sigReadValid),
      .sigReadData     (sigReadData),
      .powerupDone     (powerupDone),
      .pinOut          (pinOut),
      .pinOe_n         (pinOe_n),
      .pinSense        (pinSense)
   );
   pts_pin_board board (
      .core_clk (core_clk),
      .pinOut   (pinOut),
      .pinOe_n  (pinOe_n),
      .extDrive (extDrive),
      .extVal   (extVal),
      .pinIn    (pinIn),
      .pinFloat (pinFloat)
   );
   // ---------------------------------------------------------------
   // Clock, helpers and tasks
   // ---------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      #100;
      forever #12.5 core_clk = ~core_clk;
   end
   function automatic logic [9:0] sense(input logic [9:0] e, o);
      return (e & o) | (~e & extDrive & extVal) | (~e & ~extDrive);
   endfunction
   task automatic finish_test();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Called just after a falling edge; watches for the erased enables.
   task automatic prog_cycle(input logic [63:0] s, input logic l);
      progSignature = s;
      progPolarity = pol;
      progEnable = en;
      progLock = l;
      progLoad = 1'b1;
      @(negedge core_clk);
      progLoad = 1'b0;
      erased = 1'b0;
      repeat (6) begin
         if (pinOe_n === 10'h3FF) erased = 1'b1;
         @(negedge core_clk);
      end
      `CHK("busy", 1'b0, progBusy)
      `CHK("erase", 1'b1, erased)
   endtask
   task automatic rd(input logic c);
      // One idle edge first, so back-to-back reads never set and clear at once.
      @(negedge core_clk);
      cfgReadReq = c;
      sigReadReq = ~c;
      @(negedge core_clk);
      cfgReadReq = 1'b0;
      sigReadReq = 1'b0;
      `CHK("valid", 1'b1, c ? cfgReadValid : sigReadValid)
   endtask
   initial begin
      repeat (3000) @(posedge core_clk);
      err_total++;
      finish_test();
   end
   // Counts clock edges since reset release; the two sync flops add two.
   always @(posedge core_clk) begin
      cnt <= rst_n ? cnt + 1 : 0;
   end
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {rst_n, progLoad, progLock, cfgReadReq, sigReadReq, testMode, preloadStrobe} = 7'h00;
      {progSignature, progPolarity, progEnable, preloadState} = '0;
      extDrive = 10'($random(seed));
      extVal = 10'($random(seed));
      repeat (16) @(negedge core_clk);
      `CHK("oe_rst", 10'h3FF, pinOe_n)
      `CHK("done_rst", 1'b0, powerupDone)
      rst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      sig = {$random(seed), $random(seed)};
      pol = 10'($random(seed));
      en = 10'($random(seed)) | 10'h001;
      prog_cycle(sig, 1'b0);
      `CHK("pin_pu", ~pol, pinOut)
      `CHK("oe", ~en, pinOe_n)
      rd(1'b0);
      `CHK("sig", sig, sigReadData)
      while (cnt < 60 && powerupDone !== 1'b1) @(negedge core_clk);
      `CHK("tpr", 1'b1, cnt >= `PTS_TPR_CYC && cnt <= `PTS_TPR_CYC + 3)
      rd(1'b1);
      `CHK("ref0", 1'b0, cfgReadRefused)
      `CHK("pol", pol, cfgReadPolarity)
      `CHK("en", en, cfgReadEnable)
      testMode = 1'b1;
      for (int k = 0; k < 3; k++) begin
         st = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : 10'($random(seed));
         preloadState = st;
         preloadStrobe = 1'b1;
         @(negedge core_clk);
         preloadStrobe = 1'b0;
         `CHK("preload", st ^ ~pol, pinOut)
         @(negedge core_clk);
         `CHK("hold", st ^ ~pol, pinOut)
         `CHK("sense", sense(en, st ^ ~pol), pinSense)
         $display("preload case %0d done", k);
      end
      testMode = 1'b0;
      prog_cycle(~sig, 1'b1);
      rd(1'b1);
      `CHK("ref1", 1'b1, cfgReadRefused)
      `CHK("pol_z", 10'h000, cfgReadPolarity)
      `CHK("en_z", 10'h000, cfgReadEnable)
      rd(1'b0);
      `CHK("sig_l", ~sig, sigReadData)
      prog_cycle(sig, 1'b0);
      rd(1'b1);
      `CHK("unlock", 1'b0, cfgReadRefused)
      `CHK("pol_u", pol, cfgReadPolarity)
      $display("lock test done");
      finish_test();
   end
endmodule
